// [verilog/zero_overhead_loop_ctrl.sv]
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "zol_regs.svh"

// Contract
// RL1: loops exist only with extension parameter set
// RL2: last-to-first body jump without stall cycles
// RL3: loop is begin, finish and decrementing count
// RL4: two independent loop register sets
// RL5: set 0 inner, wins over set 1
// RL6: loop constraints unchecked, no exception raised
// RL7: program aligns setup and loop addresses
// RL8: program keeps finish above begin
// RL9: program body has three instructions minimum
// RL10: outer finish eight bytes past inner
// RL11: program enters loop only at begin
// RL12: program never rewrites active loop set
// RL13: program uses no compressed body instructions
// RL14: program puts no jumps in body
// RL15: program puts no fences in body
// RL16: only breakpoint allowed as privileged body op
// RL17: loop registers readable through custom csr space
// RL18: loop registers written only by setup instructions
// RL19: csr write to loop register is illegal
// RL20: setup forms for begin, finish, count, combined
// RL21: handler saves and restores loop registers
// RL22: count above one loops, one falls through
module zero_overhead_loop_ctrl #(
    parameter bit custom_ext_enable_param = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input zol_pkg::setup_req_t setup_req,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_pc,
    input wire logic ex_valid,
    input wire logic [31:0] ex_pc,
    input zol_pkg::csr_req_t csr_req,
    output zol_pkg::csr_rsp_t csr_rsp,
    output zol_pkg::fetch_jump_t fetch_jump
);

    zol_pkg::loop_view_t views [2];
    logic [1:0] arm_hit;
    logic [1:0] last_fetch;
    logic [1:0] last_exec;
    logic loops_enable;
    logic next_loops_enable;

    // picks one loop word by set and field; shared by apb and csr reads
    function automatic logic [31:0] loop_word(
        input logic [2:0] idx,
        input zol_pkg::loop_view_t v0,
        input zol_pkg::loop_view_t v1
    );
        zol_pkg::loop_view_t v;
        logic [31:0] w;
        v = idx[2] ? v1 : v0;
        case (idx[1:0])
            `ZOL_FIELD_BEGIN:
            begin
                w = v.begin_addr;
            end
            `ZOL_FIELD_FINISH:
            begin
                w = v.finish_addr;
            end
            `ZOL_FIELD_ITER:
            begin
                w = v.iterations;
            end
            default:
            begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    function automatic logic field_used(input logic [2:0] idx);
        return idx[1:0] != 2'h3;
    endfunction

    generate
        if (custom_ext_enable_param) // see RL1
        begin : g_loops
            for (genvar g = 0; g < 2; g++)
            begin : g_set
                zol_loop_set #(
                    .SET_ID(1'(g))
                ) u_set (
                    .mclk(mclk),
                    .rst_b(rst_b),
                    .setup(setup_req), // see RL18
                    .enable(loops_enable),
                    .fetch_valid(fetch_valid),
                    .fetch_pc(fetch_pc),
                    .ex_valid(ex_valid),
                    .ex_pc(ex_pc),
                    .view(views[g]),
                    .arm_hit(arm_hit[g]),
                    .last_fetch(last_fetch[g]),
                    .last_exec(last_exec[g])
                );
            end
        end
        else
        begin : g_no_loops
            assign views[0] = '0;
            assign views[1] = '0;
            assign arm_hit = 2'h0;
            assign last_fetch = 2'h0;
            assign last_exec = 2'h0;
        end
    endgenerate

    // redirect state: armed one instruction before the last body fetch, so
    // the target is already in a flop when fetch reaches the last word
    zol_pkg::redirect_state_t state;
    zol_pkg::redirect_state_t next_state;
    zol_pkg::fetch_jump_t next_fetch_jump;
    logic armed_set;
    logic next_armed_set;
    logic [31:0] armed_pc;
    logic [31:0] next_armed_pc;
    logic stray_fetch;

    always_comb
    begin
        next_state = state;
        next_fetch_jump = fetch_jump;
        next_armed_set = armed_set;
        next_armed_pc = armed_pc;
        // fetch wandered off (trap or flush): drop the pending redirect
        stray_fetch = fetch_valid && !last_fetch[armed_set] && (fetch_pc != armed_pc);
        case (state)
            zol_pkg::RD_IDLE:
            begin
                if (arm_hit[0]) // see RL5
                begin
                    next_state = zol_pkg::RD_ARMED;
                    next_armed_set = 1'b0;
                    next_armed_pc = fetch_pc;
                    next_fetch_jump.valid = 1'b1;
                    next_fetch_jump.target = views[0].begin_addr;
                end
                else if (arm_hit[1])
                begin
                    next_state = zol_pkg::RD_ARMED;
                    next_armed_set = 1'b1;
                    next_armed_pc = fetch_pc;
                    next_fetch_jump.valid = 1'b1;
                    next_fetch_jump.target = views[1].begin_addr;
                end
            end
            zol_pkg::RD_ARMED:
            begin
                // fetch takes target in the cycle it fetches the last word
                if (last_fetch[armed_set] || stray_fetch || !loops_enable) // see RL2
                begin
                    next_state = zol_pkg::RD_IDLE;
                    next_fetch_jump.valid = 1'b0;
                end
            end
            default:
            begin
                next_state = zol_pkg::RD_IDLE;
                next_fetch_jump.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= zol_pkg::RD_IDLE;
            fetch_jump <= '0;
            armed_set <= 1'b0;
            armed_pc <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            fetch_jump <= next_fetch_jump;
            armed_set <= next_armed_set;
            armed_pc <= next_armed_pc;
        end
    end

    // csr read path; writes are refused rather than silently dropped
    zol_pkg::csr_rsp_t next_csr_rsp;
    logic csr_hit;
    logic [2:0] csr_idx;

    always_comb
    begin
        csr_idx = csr_req.addr[2:0];
        csr_hit = csr_req.valid && (csr_req.addr[11:3] == 9'(`ZOL_CSR_LOOP_BASE >> 3));
        next_csr_rsp.done = csr_hit;
        next_csr_rsp.illegal = csr_hit && (csr_req.write || !custom_ext_enable_param
            || !field_used(csr_idx)); // see RL19
        next_csr_rsp.rdata = 32'h0000_0000;
        if (csr_hit && !next_csr_rsp.illegal)
        begin
            next_csr_rsp.rdata = loop_word(csr_idx, views[0], views[1]); // see RL17
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            csr_rsp <= '0;
        end
        else
        begin
            csr_rsp <= next_csr_rsp;
        end
    end

    // apb slave: one wait state, write commits on the pready edge
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic apb_first;
    logic apb_commit;
    logic loop_win;
    logic [2:0] apb_idx;
    logic [31:0] status_word;

    always_comb
    begin
        apb_first = psel && penable && !pready;
        apb_commit = psel && penable && pready;
        apb_idx = paddr[4:2];
        loop_win = (paddr[11:5] == 7'(`ZOL_APB_LOOP_BASE >> 5)) && (paddr[1:0] == 2'h0);
        status_word = 32'h0000_0000;
        status_word[`ZOL_STAT_ACTIVE0_BIT] = views[0].iterations != 32'h0000_0000;
        status_word[`ZOL_STAT_ACTIVE1_BIT] = views[1].iterations != 32'h0000_0000;
        status_word[`ZOL_STAT_ARMED_BIT] = state == zol_pkg::RD_ARMED;
        status_word[`ZOL_STAT_ARMED_SET_BIT] = armed_set;
        status_word[`ZOL_STAT_PRESENT_BIT] = custom_ext_enable_param;
        next_pready = apb_first;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        next_loops_enable = loops_enable;
        if (apb_first)
        begin
            if (paddr == `ZOL_APB_CTRL)
            begin
                next_prdata[`ZOL_CTRL_ENABLE_BIT] = loops_enable;
            end
            else if (paddr == `ZOL_APB_STATUS)
            begin
                next_prdata = status_word;
                next_pslverr = pwrite;
            end
            else if (loop_win && field_used(apb_idx))
            begin
                // loop words are a read-only mirror of the csr view
                next_prdata = pwrite ? 32'h0000_0000 : loop_word(apb_idx, views[0], views[1]);
                next_pslverr = pwrite; // see RL18
            end
            else
            begin
                next_pslverr = 1'b1;
            end
        end
        if (apb_commit && pwrite && (paddr == `ZOL_APB_CTRL))
        begin
            next_loops_enable = pwdata[`ZOL_CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            loops_enable <= 1'(`ZOL_CTRL_RESET);
        end
        else
        begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            loops_enable <= next_loops_enable;
        end
    end

    // no range, order or alignment checks here: a broken loop program simply
    // misbehaves, which keeps adders and comparators off the fetch path
    logic unused_exec;
    assign unused_exec = |last_exec; // see RL6

endmodule

// [verilog/zol_regs.svh]
`ifndef ZOL_REGS_SVH
`define ZOL_REGS_SVH

// register window offsets
`define ZOL_APB_CTRL 12'h000
`define ZOL_APB_STATUS 12'h004
`define ZOL_APB_LOOP_BASE 12'h020

// control register fields and reset
`define ZOL_CTRL_ENABLE_BIT 0
`define ZOL_CTRL_RESET 32'h0000_0001

// status register fields
`define ZOL_STAT_ACTIVE0_BIT 0
`define ZOL_STAT_ACTIVE1_BIT 1
`define ZOL_STAT_ARMED_BIT 2
`define ZOL_STAT_ARMED_SET_BIT 3
`define ZOL_STAT_PRESENT_BIT 4

// custom read-only csr window for the loop registers
`define ZOL_CSR_LOOP_BASE 12'hCC0

// fields inside one loop set's word group
`define ZOL_FIELD_BEGIN 2'h0
`define ZOL_FIELD_FINISH 2'h1
`define ZOL_FIELD_ITER 2'h2

// one full-width instruction, and the look-ahead distance for arming
`define ZOL_INSTR_BYTES 32'h0000_0004
`define ZOL_ARM_BYTES 32'h0000_0008

`endif

// [verilog/zol_pkg.sv]
package zol_pkg;

    typedef enum logic [1:0] {
        SETUP_BEGIN = 2'b00,
        SETUP_FINISH = 2'b01,
        SETUP_ITER = 2'b10,
        SETUP_COMBINED = 2'b11
    } setup_op_t;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_ARMED = 1'b1
    } redirect_state_t;

    typedef struct packed {
        logic valid;
        logic set_idx;
        setup_op_t op;
        logic [31:0] begin_addr;
        logic [31:0] finish_addr;
        logic [31:0] iterations;
    } setup_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } csr_req_t;

    typedef struct packed {
        logic done;
        logic illegal;
        logic [31:0] rdata;
    } csr_rsp_t;

    typedef struct packed {
        logic valid;
        logic [31:0] target;
    } fetch_jump_t;

    typedef struct packed {
        logic [31:0] begin_addr;
        logic [31:0] finish_addr;
        logic [31:0] iterations;
    } loop_view_t;

endpackage

// [verilog/zol_loop_set.sv]
`timescale 1ns/1ns
`include "zol_regs.svh"

module zol_loop_set #(
    parameter bit SET_ID = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_b,
    input zol_pkg::setup_req_t setup,
    input wire logic enable,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_pc,
    input wire logic ex_valid,
    input wire logic [31:0] ex_pc,
    output zol_pkg::loop_view_t view,
    output logic arm_hit,
    output logic last_fetch,
    output logic last_exec
);

    // fetch runs ahead of execute, so it keeps its own count of passes left
    logic [31:0] fetch_left;
    logic [31:0] next_fetch_left;
    zol_pkg::loop_view_t next_view;
    logic [31:0] last_pc;
    logic [31:0] arm_pc;
    logic load;

    always_comb
    begin
        last_pc = view.finish_addr - `ZOL_INSTR_BYTES; // see RL3
        arm_pc = view.finish_addr - `ZOL_ARM_BYTES;
        load = setup.valid && (setup.set_idx == SET_ID);
        last_exec = enable && ex_valid && (ex_pc == last_pc) && (view.iterations != 32'h0000_0000);
        last_fetch = enable && fetch_valid && (fetch_pc == last_pc)
            && (fetch_left != 32'h0000_0000);
        arm_hit = enable && fetch_valid && (fetch_pc == arm_pc)
            && (fetch_left > 32'h0000_0001); // see RL22
        next_view = view;
        next_fetch_left = fetch_left;
        if (last_exec)
        begin
            next_view.iterations = view.iterations - 32'h0000_0001; // see RL3
        end
        if (last_fetch)
        begin
            next_fetch_left = fetch_left - 32'h0000_0001;
        end
        // an iter or combined setup overrides a same-cycle decrement; begin or finish setups keep it
        if (load)
        begin
            case (setup.op) // see RL20
                zol_pkg::SETUP_BEGIN:
                begin
                    next_view.begin_addr = setup.begin_addr;
                end
                zol_pkg::SETUP_FINISH:
                begin
                    next_view.finish_addr = setup.finish_addr;
                end
                zol_pkg::SETUP_ITER:
                begin
                    next_view.iterations = setup.iterations;
                    next_fetch_left = setup.iterations;
                end
                zol_pkg::SETUP_COMBINED:
                begin
                    next_view.begin_addr = setup.begin_addr;
                    next_view.finish_addr = setup.finish_addr;
                    next_view.iterations = setup.iterations;
                    next_fetch_left = setup.iterations;
                end
                default:
                begin
                    next_view = view;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            view <= '0;
            fetch_left <= 32'h0000_0000;
        end
        else
        begin
            view <= next_view; // see RL4
            fetch_left <= next_fetch_left;
        end
    end

endmodule

// [verification/zero_overhead_loop_ctrl_assertions.sv]
`timescale 1ns/1ns
module zol_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input zol_pkg::csr_req_t csr_req,
    input zol_pkg::csr_rsp_t csr_rsp,
    input wire logic fetch_valid,
    input zol_pkg::fetch_jump_t fetch_jump
);
    logic hit;
    // loop window is 0xCC0..0xCC7
    assign hit = csr_req.valid && csr_req.addr[11:3] == 9'h198;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_CSR_ANSWER: assert property (hit |=> csr_rsp.done)
        else $error("csr answer missing");
    AST_CSR_WR_ILLEGAL: assert property (hit && csr_req.write |=> csr_rsp.illegal
        && csr_rsp.rdata == 32'h0)
        else $error("csr write accepted");
    AST_CSR_QUIET: assert property (!hit |=> !csr_rsp.done)
        else $error("csr answer without request");
    AST_RD_LEGAL: assert property (hit && !csr_req.write && csr_req.addr[1:0] != 2'h3
        |=> !csr_rsp.illegal)
        else $error("csr read refused");
    AST_JUMP_ON_FETCH: assert property ($rose(fetch_jump.valid) |-> $past(fetch_valid))
        else $error("redirect armed without fetch");
    AST_JUMP_USED: assert property (fetch_jump.valid && fetch_valid |=> !fetch_jump.valid)
        else $error("redirect not cleared");
    AST_JUMP_HOLD: assert property (fetch_jump.valid && !fetch_valid
        && !$past(psel && penable && pwrite && pready)
        |=> fetch_jump.valid && $stable(fetch_jump.target))
        else $error("redirect lost during stall");
endmodule

// [verification/zol_fetch_model.sv]
`timescale 1ns/1ns
module zol_fetch_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic slow,
    input wire logic [31:0] start_pc,
    input wire logic [31:0] stop_pc,
    input zol_pkg::fetch_jump_t fetch_jump,
    output logic fetch_valid,
    output logic [31:0] fetch_pc,
    output logic ex_valid,
    output logic [31:0] ex_pc,
    output logic busy,
    output logic [7:0] n_fetched
);
    logic [31:0] nxt;
    logic [31:0] cand;
    logic ph;
    // whole words in order; the redirect is the only jump
    assign cand = !fetch_valid ? nxt : fetch_jump.valid ? fetch_jump.target
        : fetch_pc + 32'h0000_0004;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {fetch_valid, ex_valid, busy, ph} <= 4'h0;
            {fetch_pc, ex_pc, nxt} <= '0;
            n_fetched <= 8'h00;
        end
        else
        begin
            ex_valid <= fetch_valid;
            // an empty slot shows a moving pattern, not the last pc
            ex_pc <= fetch_valid ? fetch_pc : ~ex_pc;
            ph <= ~ph;
            nxt <= cand;
            if (go)
            begin
                busy <= 1'h1;
                nxt <= start_pc;
                n_fetched <= 8'h00;
                ph <= 1'h0;
            end
            if (busy && (!slow || ph))
            begin
                fetch_valid <= 1'h1;
                fetch_pc <= cand;
                n_fetched <= n_fetched + 8'h01;
                busy <= cand != stop_pc;
            end
            else
            begin
                fetch_valid <= 1'h0;
                fetch_pc <= ~fetch_pc;
            end
        end
    end
endmodule

// [verification/zero_overhead_loop_ctrl_tb_top.sv]
`timescale 1ns/1ns
module zero_overhead_loop_ctrl_tb_top;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, go, slow, fetch_valid;
    logic ex_valid, busy, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, start_pc, stop_pc, ex_pc, fetch_pc, rd;
    logic [7:0] n_fetched;
    zol_pkg::setup_req_t setup_req;
    zol_pkg::csr_req_t csr_req;
    zol_pkg::csr_rsp_t csr_rsp, rsp;
    zol_pkg::fetch_jump_t fetch_jump;
    int errors, n_compared;

    zero_overhead_loop_ctrl u_zero_overhead_loop_ctrl (.mclk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .setup_req, .fetch_valid,
        .fetch_pc, .ex_valid, .ex_pc, .csr_req, .csr_rsp, .fetch_jump);
    zol_fetch_model u_zol_fetch_model (.mclk, .rst_b, .go, .slow, .start_pc, .stop_pc,
        .fetch_jump, .fetch_valid, .fetch_pc, .ex_valid, .ex_pc, .busy, .n_fetched);

    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task complete_run;
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task csr(input logic w, input logic [11:0] a);
        @(posedge mclk);
        csr_req <= '{1'h1, w, a, 32'hFFFF_FFFF};
        @(posedge mclk);
        csr_req.valid <= 1'h0;
        @(posedge mclk);
        rsp = csr_rsp;
    endtask

    task su(input logic s, input zol_pkg::setup_op_t op, input logic [31:0] b,
        input logic [31:0] f, input logic [31:0] c);
        @(posedge mclk);
        setup_req <= '{1'h1, s, op, b, f, c};
        @(posedge mclk);
        setup_req.valid <= 1'h0;
    endtask

    // outside slow mode every fetch slot is a valid pc; the fetch count exposes any missed redirect
    task run(input logic [31:0] a, input logic [31:0] z, input logic s, input logic [31:0] e);
        @(posedge mclk);
        go <= 1'h1;
        start_pc <= a;
        stop_pc <= z;
        slow <= s;
        @(posedge mclk);
        go <= 1'h0;
        do
        begin
            @(posedge mclk);
        end
        while (busy !== 1'h0);
        repeat (3) @(posedge mclk);
        chk("fetches", {24'h0, n_fetched}, e);
    endtask

    initial
    begin
        {rst_b, psel, penable, pwrite, go, slow} = '0;
        {paddr, pwdata, start_pc, stop_pc} = '0;
        setup_req = '0;
        csr_req = '0;
        errors = 0;
        n_compared = 0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'h1;
        apb(1'h0, 12'h000, 32'h0);
        chk("ctrl", rd, 32'h0000_0001);
        apb(1'h0, 12'h004, 32'h0);
        chk("status", rd, 32'h0000_0010);
        apb(1'h1, 12'h004, 32'hFFFF_FFFF);
        chk("status wr", {31'h0, er}, 32'h1);
        apb(1'h0, 12'h100, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        su(1'h0, zol_pkg::SETUP_BEGIN, 32'h0000_0100, 32'h0, 32'h0);
        su(1'h0, zol_pkg::SETUP_FINISH, 32'h0, 32'h0000_010C, 32'h0);
        su(1'h0, zol_pkg::SETUP_ITER, 32'h0, 32'h0, 32'h0000_0002);
        for (int i = 0; i < 3; i++)
        begin
            csr(1'h0, 12'hCC0 + 12'(i));
            chk("csr set0", rsp.rdata, i == 0 ? 32'h100 : i == 1 ? 32'h10C : 32'h2);
        end
        apb(1'h1, 12'h028, 32'h0000_0005);
        chk("loop wr", {31'h0, er}, 32'h1);
        csr(1'h1, 12'hCC2);
        chk("csr wr", {rsp.illegal, rsp.rdata[30:0]}, 32'h8000_0000);
        csr(1'h0, 12'hCC2);
        chk("count kept", rsp.rdata, 32'h2);
        csr(1'h0, 12'hCC3);
        chk("csr idx3", {31'h0, rsp.illegal}, 32'h1);
        csr(1'h0, 12'hCC8);
        chk("csr other", {31'h0, rsp.done}, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk("status act", rd, 32'h0000_0011);
        for (int c = 1; c <= 3; c++)
        begin
            su(1'h0, zol_pkg::SETUP_COMBINED, 32'h100, 32'h10C, 32'(c));
            run(32'hF8, 32'h10C, c == 2, 32'(3 * c + 3));
            csr(1'h0, 12'hCC2);
            chk("count end", rsp.rdata, 32'h0);
        end
        // disabled: the body runs once and falls through
        apb(1'h1, 12'h000, 32'h0);
        su(1'h0, zol_pkg::SETUP_ITER, 32'h0, 32'h0, 32'h3);
        run(32'hF8, 32'h10C, 1'h0, 32'h6);
        apb(1'h1, 12'h000, 32'h1);
        su(1'h1, zol_pkg::SETUP_COMBINED, 32'h1F8, 32'h214, 32'h2);
        su(1'h0, zol_pkg::SETUP_COMBINED, 32'h200, 32'h20C, 32'h2);
        run(32'h1F8, 32'h214, 1'h0, 32'h12);
        apb(1'h0, 12'h034, 32'h0);
        chk("set1 finish", rd, 32'h214);
        csr(1'h0, 12'hCC6);
        chk("set1 count", rsp.rdata, 32'h0);
        // handler-style save, clobber and restore of a loop register
        csr(1'h0, 12'hCC5);
        rd = rsp.rdata;
        su(1'h1, zol_pkg::SETUP_FINISH, 32'h0, 32'h0, 32'h0);
        csr(1'h0, 12'hCC5);
        chk("clobbered", rsp.rdata, 32'h0);
        su(1'h1, zol_pkg::SETUP_FINISH, 32'h0, rd, 32'h0);
        csr(1'h0, 12'hCC5);
        chk("restored", rsp.rdata, 32'h214);
        complete_run;
    end

    initial
    begin
        repeat (4000) @(posedge mclk);
        errors++;
        complete_run;
    end
endmodule

bind zero_overhead_loop_ctrl zol_checker u_zol_checker (.mclk, .rst_b, .psel, .penable,
    .pwrite, .pready, .pslverr, .csr_req, .csr_rsp, .fetch_valid, .fetch_jump);
